// *** common/rtlc_pkg.sv ***
// shared types and constants of the test loopback control block
package rtlc_pkg;

    // ------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------
    localparam int RTLC_WORD_W = 16;
    localparam int RTLC_CHAN_W = 3;
    localparam int RTLC_CNT_W = 9;
    localparam logic [RTLC_CNT_W-1:0] RTLC_BURST_BITS = 9'h072;
    localparam logic [RTLC_CNT_W-1:0] RTLC_SPEECH_BITS = 9'h104;
    localparam logic [RTLC_CNT_W-1:0] RTLC_EFS_BITS = 9'h0f4;
    localparam logic [RTLC_CNT_W-1:0] RTLC_DATA_BITS = 9'h1ff;
    localparam logic [2:0] RTLC_CTRL_SAPI = 3'h0;
    localparam int RTLC_MAX_RTD_FRAMES = 26;
    localparam int RTLC_FIFO_DEPTH = 4;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic RTLC_CLOSED_RST = 1'b0;
    localparam logic RTLC_DAI_RST = 1'b0;

    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        RTLC_LOOP_A = 6'h01,
        RTLC_LOOP_B = 6'h02,
        RTLC_LOOP_C = 6'h04,
        RTLC_LOOP_D = 6'h08,
        RTLC_LOOP_E = 6'h10,
        RTLC_LOOP_F = 6'h20
    } rtlc_variant_t;

    typedef enum logic [3:0] {
        RTLC_OP_CLOSE = 4'h1,
        RTLC_OP_OPEN = 4'h2,
        RTLC_OP_DAI_ON = 4'h4,
        RTLC_OP_DAI_OFF = 4'h8
    } rtlc_op_t;

    typedef enum logic [3:0] {
        RTLC_TCH_FS = 4'h1,
        RTLC_TCH_HS = 4'h2,
        RTLC_TCH_EFS = 4'h4,
        RTLC_TCH_DATA = 4'h8
    } rtlc_tch_t;

    localparam logic [1:0] RTLC_SID_ERASED = 2'h0;
    localparam logic [1:0] RTLC_SID_VALID = 2'h2;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        rtlc_op_t op;
        rtlc_variant_t variant;
        logic [RTLC_CHAN_W-1:0] chan;
        logic [2:0] sapi;
        logic on_dcch;
        logic ack_mode;
    } rtlc_cmd_t;

    typedef struct packed {
        logic [RTLC_WORD_W-1:0] data;
        logic first;
        logic last;
        logic burst;
        logic traffic;
        logic tsc_ok;
        logic [1:0] steal;
        logic bfi;
        logic ufi;
        logic facch;
        logic [1:0] sid;
        logic [RTLC_CHAN_W-1:0] chan;
    } rtlc_rx_t;

    typedef struct packed {
        logic [RTLC_WORD_W-1:0] data;
        logic last;
        logic burst;
    } rtlc_tx_t;

endpackage

// *** rtl/rtlc_fifo.sv ***
// small word fifo with a registered read stage
`timescale 1ns/1ps
`default_nettype none
module rtlc_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic push;
    logic pop;

    // ------------------------------------------------------------
    // pointers and fill level
    // ------------------------------------------------------------
    assign push = in_valid && in_ready;
    assign pop = (cnt_q != '0) && (!out_valid || out_ready);

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + (AW+1)'(1);
        end else if (pop && !push) begin
            cnt_d = cnt_q - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
            end
            cnt_q <= cnt_d;
            // ready is registered so the source sees a clean level
            in_ready <= (cnt_d < (AW+1)'(DEPTH));
        end
    end

    // ------------------------------------------------------------
    // storage and read register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data <= mem_q[rd_q];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** rtl/rtlc_top.sv ***
// test loopback control: command handling and looped data path
//
// Contract
// RULE1 - test functions switch on and off only through layer 3 commands
// RULE2 - commands count only on control channel, link access point zero, acked
// RULE3 - power-off or test SIM removal ends every active test function
// RULE4 - traffic loop and digital audio test never active together
// RULE5 - test functions can be activated only with a test SIM inserted
// RULE6 - loop closes only while a traffic channel is active
// RULE7 - burst loop sends 114 decrypted undecoded bits, stealing flags dropped
// RULE8 - burst loop returns content whatever the training sequence state
// RULE9 - uplink looped bursts use the station's own training sequence
// RULE10 - burst loop skips control and idle bursts, loops traffic only
// RULE11 - speech frame loops carry 244 bits on enhanced rate, else 260
// RULE12 - six single-slot loop variants are supported
// RULE13 - close command ignored with no traffic channel or loop closed
// RULE14 - bad frames are replaced by an all-zero frame uplink; code zeroes them in A, D, F (valid SID) and E (erased SID), not in B or C
// RULE15 - burst loop round trip stays below 26 frames
// RULE16 - variant and channel stay fixed until the loop is opened
`timescale 1ns/1ps
`default_nettype none
module rtlc_top
    import rtlc_pkg::*;
#(
    parameter int FIFO_DEPTH = RTLC_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic power_on,
    input wire logic test_sim,
    input wire logic tch_active,
    input wire rtlc_tch_t tch_kind,
    input wire logic cmd_valid,
    input wire rtlc_cmd_t cmd,
    input wire logic rx_valid,
    input wire rtlc_rx_t rx,
    output logic rx_ready,
    output logic tx_valid,
    output rtlc_tx_t tx,
    input wire logic tx_ready,
    output logic tx_own_tsc,
    output logic close_ack,
    output logic loop_closed,
    output logic dai_active,
    output rtlc_variant_t loop_variant,
    output logic [RTLC_CHAN_W-1:0] loop_chan
);

    // ------------------------------------------------------------
    // command qualification
    // ------------------------------------------------------------
    logic cmd_ok;
    logic abort;
    logic do_close;
    logic do_open;
    logic do_dai_on;
    logic do_dai_off;

    // anything off the acknowledged control path is not a test command
    assign cmd_ok = cmd_valid && cmd.on_dcch && cmd.ack_mode
        && (cmd.sapi == RTLC_CTRL_SAPI); // see RULE2

    // losing power or the test SIM tears everything down
    assign abort = !power_on || !test_sim; // see RULE3

    assign do_close = cmd_ok && test_sim && (cmd.op == RTLC_OP_CLOSE)
        && tch_active && !loop_closed && !dai_active; // see RULE5 see RULE6 see RULE13
    assign do_open = cmd_ok && (cmd.op == RTLC_OP_OPEN); // see RULE1
    assign do_dai_on = cmd_ok && test_sim && (cmd.op == RTLC_OP_DAI_ON)
        && !loop_closed; // see RULE4
    assign do_dai_off = cmd_ok && (cmd.op == RTLC_OP_DAI_OFF);

    // ------------------------------------------------------------
    // loop state
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset || abort) begin
            loop_closed <= RTLC_CLOSED_RST; // see RULE3
        end else if (do_close) begin
            loop_closed <= 1'b1; // see RULE1
        end else if (do_open) begin
            loop_closed <= 1'b0;
        end
    end

    // variant and channel latch only on closure
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            loop_variant <= RTLC_LOOP_A;
            loop_chan <= '0;
        end else if (do_close) begin
            loop_variant <= cmd.variant; // see RULE12 see RULE16
            loop_chan <= cmd.chan; // see RULE16
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || abort) begin
            dai_active <= RTLC_DAI_RST; // see RULE3
        end else if (do_dai_on) begin
            dai_active <= 1'b1; // see RULE4
        end else if (do_dai_off) begin
            dai_active <= 1'b0;
        end
    end

    // one-cycle strobe asking the layer 3 side to send the acknowledge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            close_ack <= 1'b0;
        end else begin
            close_ack <= do_close && !abort;
        end
    end

    // ------------------------------------------------------------
    // frame length by channel kind
    // ------------------------------------------------------------
    logic burst_mode;
    logic [RTLC_CNT_W-1:0] limit;

    assign burst_mode = (loop_variant == RTLC_LOOP_C);

    always_comb begin
        limit = RTLC_SPEECH_BITS; // see RULE11
        if (burst_mode) begin
            limit = RTLC_BURST_BITS; // see RULE7
        end else if (tch_kind == RTLC_TCH_EFS) begin
            limit = RTLC_EFS_BITS; // see RULE11
        end else if (tch_kind == RTLC_TCH_DATA) begin
            limit = RTLC_DATA_BITS;
        end
    end

    // ------------------------------------------------------------
    // bad frame marking per variant
    // ------------------------------------------------------------
    logic bad_now;

    always_comb begin
        bad_now = 1'b0;
        unique case (loop_variant)
            RTLC_LOOP_A: begin
                // facch response is open here, zero is the safe answer
                bad_now = rx.bfi || rx.facch; // see RULE14
            end
            RTLC_LOOP_B: begin
                bad_now = 1'b0;
            end
            RTLC_LOOP_C: begin
                bad_now = 1'b0;
            end
            RTLC_LOOP_D: begin
                bad_now = rx.bfi || rx.ufi || rx.facch; // see RULE14
            end
            RTLC_LOOP_E: begin
                bad_now = (rx.sid == RTLC_SID_ERASED) || rx.facch; // see RULE14
            end
            RTLC_LOOP_F: begin
                bad_now = ((rx.sid == RTLC_SID_VALID) && rx.bfi) || rx.facch; // see RULE14
            end
            default: begin
                bad_now = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // word selection and trimming
    // ------------------------------------------------------------
    logic fifo_ready;
    logic take;
    logic wanted;
    logic zero_q;
    logic zero_eff;
    logic [RTLC_CNT_W-1:0] bits_q;
    logic [RTLC_CNT_W-1:0] bits_eff;
    logic [RTLC_CNT_W-1:0] left;
    logic [RTLC_WORD_W-1:0] mask;
    logic push;
    rtlc_tx_t push_word;

    assign take = rx_valid && fifo_ready;

    // training sequence state is never looked at in burst mode
    always_comb begin
        wanted = 1'b0;
        if (loop_closed && tch_active) begin
            if (burst_mode) begin
                wanted = rx.burst && rx.traffic; // see RULE10 see RULE8
            end else begin
                wanted = !rx.burst && (rx.chan == loop_chan);
            end
        end
    end

    assign bits_eff = rx.first ? '0 : bits_q;
    assign left = limit - bits_eff;
    assign zero_eff = rx.first ? bad_now : zero_q;
    assign push = take && wanted && (left != '0);

    // keep the top bits of a partial last word; stealing flags travel
    // separately and are never part of the looped bits
    always_comb begin
        mask = '1;
        if (left < RTLC_CNT_W'(RTLC_WORD_W)) begin
            mask = ~({RTLC_WORD_W{1'b1}} >> left[4:0]); // see RULE7 see RULE11
        end
    end

    always_comb begin
        push_word.data = zero_eff ? '0 : (rx.data & mask); // see RULE14
        push_word.last = rx.last || (left <= RTLC_CNT_W'(RTLC_WORD_W));
        push_word.burst = burst_mode;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bits_q <= '0;
        end else if (take && wanted) begin
            if (left <= RTLC_CNT_W'(RTLC_WORD_W)) begin
                bits_q <= limit;
            end else begin
                bits_q <= bits_eff + RTLC_CNT_W'(RTLC_WORD_W);
            end
        end
    end

    // the bad marking of a frame holds for all of its words
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            zero_q <= 1'b0;
        end else if (take && rx.first) begin
            zero_q <= bad_now;
        end
    end

    // ------------------------------------------------------------
    // uplink buffer
    // ------------------------------------------------------------
    // a few words of buffering keep the burst round trip far below
    // the allowed frame count; deeper buffers would eat into it
    logic [$bits(rtlc_tx_t)-1:0] fifo_out;

    rtlc_fifo #(
        .WIDTH($bits(rtlc_tx_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .reset(reset || abort),
        .in_valid(push), // see RULE15
        .in_data(push_word),
        .in_ready(fifo_ready),
        .out_valid(tx_valid),
        .out_data(fifo_out),
        .out_ready(tx_ready)
    );

    assign tx = rtlc_tx_t'(fifo_out);
    assign rx_ready = fifo_ready;

    // ------------------------------------------------------------
    // training sequence select
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tx_own_tsc <= 1'b1;
        end else begin
            tx_own_tsc <= 1'b1; // see RULE9
        end
    end

endmodule
`default_nettype wire

// *** testbench/rtlc_top_assertions.sv ***
// port-level checker for the test loopback control block
`timescale 1ns/1ps
`default_nettype none
module rtlc_top_assertions
    import rtlc_pkg::*;
#(
    parameter int FIFO_DEPTH = RTLC_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic power_on,
    input wire logic test_sim,
    input wire logic tch_active,
    input wire rtlc_tch_t tch_kind,
    input wire logic cmd_valid,
    input wire rtlc_cmd_t cmd,
    input wire logic rx_valid,
    input wire rtlc_rx_t rx,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire rtlc_tx_t tx,
    input wire logic tx_ready,
    input wire logic tx_own_tsc,
    input wire logic close_ack,
    input wire logic loop_closed,
    input wire logic dai_active,
    input wire rtlc_variant_t loop_variant,
    input wire logic [RTLC_CHAN_W-1:0] loop_chan
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic cmd_ok;
    assign cmd_ok = cmd_valid && cmd.on_dcch && cmd.ack_mode && cmd.sapi == RTLC_CTRL_SAPI;
    sequence s_close_req;
        cmd_ok && cmd.op == RTLC_OP_CLOSE && power_on && test_sim && tch_active
            && !loop_closed && !dai_active;
    endsequence
    // power or sim loss flushes the fifo, so a stall only holds while both stay up
    sequence s_stall;
        tx_valid && !tx_ready && power_on && test_sim;
    endsequence
    property p_close_taken;
        s_close_req |=> close_ack && loop_closed && loop_variant == $past(cmd.variant)
            && loop_chan == $past(cmd.chan);
    endproperty
    a_close_taken: assert property (p_close_taken) else $error("close not taken");
    property p_refuse_busy;
        cmd_valid && cmd.op == RTLC_OP_CLOSE && (loop_closed || dai_active || !tch_active)
            |=> !close_ack;
    endproperty
    a_refuse_busy: assert property (p_refuse_busy) else $error("close acked");
    property p_only_cmd;
        $rose(loop_closed) |-> $past(cmd_ok);
    endproperty
    a_only_cmd: assert property (p_only_cmd) else $error("loop closed by itself");
    property p_bad_qual;
        cmd_valid && !cmd_ok && power_on && test_sim |=> $stable(loop_closed) && $stable(dai_active);
    endproperty
    a_bad_qual: assert property (p_bad_qual) else $error("unqualified command used");
    property p_sim;
        !test_sim |=> !loop_closed && !dai_active;
    endproperty
    a_sim: assert property (p_sim) else $error("active without test sim");
    property p_power;
        !power_on |=> !loop_closed && !dai_active;
    endproperty
    a_power: assert property (p_power) else $error("active after power off");
    property p_excl;
        !(loop_closed && dai_active);
    endproperty
    a_excl: assert property (p_excl) else $error("loop and audio test together");
    property p_hold;
        loop_closed ##1 loop_closed |-> $stable(loop_variant) && $stable(loop_chan);
    endproperty
    a_hold: assert property (p_hold) else $error("variant moved while closed");
    property p_tsc;
        !$past(reset) |-> tx_own_tsc;
    endproperty
    a_tsc: assert property (p_tsc) else $error("own training sequence off");
    property p_tx_hold;
        s_stall |=> tx_valid && $stable(tx);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx word dropped in stall");
endmodule
`default_nettype wire

// *** testbench/rtlc_sim_model.sv ***
// far-side model of the test equipment: sinks and records looped words
`timescale 1ns/1ps
`default_nettype none
module rtlc_sim_model
    import rtlc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [1:0] mode,
    input wire logic tx_valid,
    input wire rtlc_tx_t tx,
    output logic tx_ready
);
    // ------------------------------------------------------------
    // sink
    // ------------------------------------------------------------
    rtlc_tx_t q[$];
    logic tog_q;
    always_ff @(posedge clk_sys) begin
        tog_q <= reset ? 1'b0 : !tog_q;
    end
    always @(posedge clk_sys) begin
        if (!reset && tx_valid && tx_ready) begin
            q.push_back(tx);
        end
    end
    // mode 0 prompt, 1 every other cycle, 2 stalled so the fifo fills
    assign tx_ready = (mode == 2'h0) || (mode == 2'h1 && tog_q);
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the test loopback control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import rtlc_pkg::*;
    ();
    logic clk_sys, reset, power_on, test_sim, tch_active, cmd_valid, rx_valid, ack, full_seen;
    logic rx_ready, tx_valid, tx_ready, tx_own_tsc, close_ack, loop_closed, dai_active;
    rtlc_tch_t tch_kind;
    rtlc_cmd_t cmd;
    rtlc_rx_t rx;
    rtlc_tx_t tx;
    rtlc_variant_t loop_variant;
    logic [RTLC_CHAN_W-1:0] loop_chan;
    logic [1:0] mode;
    int miscompares, num_checks;
    rtlc_variant_t vs[6] = '{RTLC_LOOP_A, RTLC_LOOP_B, RTLC_LOOP_C, RTLC_LOOP_D,
                             RTLC_LOOP_E, RTLC_LOOP_F};

    rtlc_top #(.FIFO_DEPTH(RTLC_FIFO_DEPTH)) uut (.clk_sys, .reset, .power_on, .test_sim,
        .tch_active, .tch_kind, .cmd_valid, .cmd, .rx_valid, .rx, .rx_ready, .tx_valid, .tx,
        .tx_ready, .tx_own_tsc, .close_ack, .loop_closed, .dai_active, .loop_variant, .loop_chan);
    rtlc_sim_model tsim (.clk_sys, .reset, .mode, .tx_valid, .tx, .tx_ready);

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = !clk_sys;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (!ok) begin
            miscompares++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic send_cmd(input rtlc_op_t op, input rtlc_variant_t v, input logic [2:0] sapi);
        @(posedge clk_sys);
        #1;
        cmd = '{op, v, 3'h1, sapi, 1'b1, 1'b1};
        cmd_valid = 1'b1;
        @(posedge clk_sys);
        #1;
        cmd_valid = 1'b0;
        ack = close_ack;
    endtask

    task automatic send_frame(input int n, input logic brst, input logic trf, input logic bad);
        int k;
        logic ok;
        @(posedge clk_sys);
        #1;
        for (int i = 0; i < n; i++) begin
            rx = '{16'ha5a5, i == 0, i == n - 1, brst, trf, 1'b0, 2'h3, bad, 1'b0, 1'b0,
                   RTLC_SID_VALID, 3'h1};
            rx_valid = 1'b1;
            k = 0;
            do begin
                ok = rx_ready;
                full_seen |= !ok;
                @(posedge clk_sys);
                k++;
            end while (!ok && k < 300);
            if (!ok) begin
                chk(1'b0, "rx word never taken");
                results();
            end
            #1;
        end
        rx_valid = 1'b0;
    endtask

    task automatic expect_words(input int bits, input logic [15:0] d, input logic brst);
        int n;
        int k;
        logic [15:0] m;
        n = (bits + 15) / 16;
        m = (bits % 16 == 0) ? 16'hffff : 16'hffff << (16 - bits % 16);
        k = 0;
        while (tsim.q.size() < n && k < 600) begin
            @(posedge clk_sys);
            k++;
        end
        if (tsim.q.size() < n) begin
            chk(1'b0, "looped words never came");
            results();
        end
        repeat (20) @(posedge clk_sys);
        chk(tsim.q.size() == n, "looped word count");
        for (int i = 0; i < n; i++) begin
            chk(tsim.q[i].data === ((i == n - 1) ? (d & m) : d), "looped data");
            chk(tsim.q[i].last === (i == n - 1) && tsim.q[i].burst === brst, "word flags");
        end
        tsim.q.delete();
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_refuse();
        @(posedge clk_sys);
        #1;
        chk(loop_closed === 1'b0 && dai_active === 1'b0 && rx_ready === 1'b1, "reset state");
        chk(tx_own_tsc === 1'b1, "own training sequence off");
        tch_active = 1'b0;
        send_cmd(RTLC_OP_CLOSE, RTLC_LOOP_C, 3'h0);
        chk(ack === 1'b0 && loop_closed === 1'b0, "closed without channel");
        tch_active = 1'b1;
        send_cmd(RTLC_OP_CLOSE, RTLC_LOOP_C, 3'h1);
        chk(ack === 1'b0 && loop_closed === 1'b0, "closed on wrong sapi");
        test_sim = 1'b0;
        send_cmd(RTLC_OP_CLOSE, RTLC_LOOP_C, 3'h0);
        chk(ack === 1'b0 && loop_closed === 1'b0, "closed without test sim");
        test_sim = 1'b1;
        $display("done refuse");
    endtask

    task automatic t_variants();
        foreach (vs[i]) begin
            send_cmd(RTLC_OP_CLOSE, vs[i], 3'h0);
            chk(ack === 1'b1 && loop_variant === vs[i], "variant close");
            send_cmd(RTLC_OP_CLOSE, RTLC_LOOP_A, 3'h0);
            chk(ack === 1'b0 && loop_variant === vs[i], "second close");
            send_cmd(RTLC_OP_OPEN, vs[i], 3'h0);
            chk(loop_closed === 1'b0, "open");
        end
        $display("done variants");
    endtask

    task automatic t_loops();
        mode = 2'h1;
        send_cmd(RTLC_OP_CLOSE, RTLC_LOOP_C, 3'h0);
        send_frame(8, 1'b1, 1'b0, 1'b0);
        send_frame(8, 1'b1, 1'b1, 1'b0);
        expect_words(RTLC_BURST_BITS, 16'ha5a5, 1'b1);
        send_cmd(RTLC_OP_OPEN, RTLC_LOOP_C, 3'h0);
        tch_kind = RTLC_TCH_EFS;
        mode = 2'h2;
        send_cmd(RTLC_OP_CLOSE, RTLC_LOOP_A, 3'h0);
        fork
            send_frame(16, 1'b0, 1'b1, 1'b1);
            begin
                repeat (30) @(posedge clk_sys);
                #1;
                mode = 2'h1;
            end
        join
        expect_words(RTLC_EFS_BITS, 16'h0000, 1'b0);
        chk(full_seen === 1'b1, "fifo never refused");
        send_cmd(RTLC_OP_OPEN, RTLC_LOOP_A, 3'h0);
        tch_kind = RTLC_TCH_FS;
        send_cmd(RTLC_OP_CLOSE, RTLC_LOOP_B, 3'h0);
        send_frame(17, 1'b0, 1'b1, 1'b0);
        expect_words(RTLC_SPEECH_BITS, 16'ha5a5, 1'b0);
        send_cmd(RTLC_OP_OPEN, RTLC_LOOP_B, 3'h0);
        // bad frames with a valid silence descriptor: d and f zero them, e passes them
        send_cmd(RTLC_OP_CLOSE, RTLC_LOOP_D, 3'h0);
        send_frame(17, 1'b0, 1'b1, 1'b1);
        expect_words(RTLC_SPEECH_BITS, 16'h0000, 1'b0);
        send_cmd(RTLC_OP_OPEN, RTLC_LOOP_D, 3'h0);
        send_cmd(RTLC_OP_CLOSE, RTLC_LOOP_E, 3'h0);
        send_frame(17, 1'b0, 1'b1, 1'b1);
        expect_words(RTLC_SPEECH_BITS, 16'ha5a5, 1'b0);
        send_cmd(RTLC_OP_OPEN, RTLC_LOOP_E, 3'h0);
        send_cmd(RTLC_OP_CLOSE, RTLC_LOOP_F, 3'h0);
        send_frame(17, 1'b0, 1'b1, 1'b1);
        expect_words(RTLC_SPEECH_BITS, 16'h0000, 1'b0);
        send_cmd(RTLC_OP_OPEN, RTLC_LOOP_F, 3'h0);
        $display("done loops");
    endtask

    task automatic t_dai();
        send_cmd(RTLC_OP_CLOSE, RTLC_LOOP_A, 3'h0);
        send_cmd(RTLC_OP_DAI_ON, RTLC_LOOP_A, 3'h0);
        chk(dai_active === 1'b0 && loop_closed === 1'b1, "audio test beside loop");
        send_cmd(RTLC_OP_OPEN, RTLC_LOOP_A, 3'h0);
        send_cmd(RTLC_OP_DAI_ON, RTLC_LOOP_A, 3'h0);
        chk(dai_active === 1'b1, "audio test on");
        send_cmd(RTLC_OP_CLOSE, RTLC_LOOP_A, 3'h0);
        chk(ack === 1'b0 && loop_closed === 1'b0, "loop beside audio test");
        send_cmd(RTLC_OP_DAI_OFF, RTLC_LOOP_A, 3'h0);
        chk(dai_active === 1'b0, "audio test off");
        send_cmd(RTLC_OP_DAI_ON, RTLC_LOOP_A, 3'h0);
        power_on = 1'b0;
        @(posedge clk_sys);
        #1;
        power_on = 1'b1;
        chk(dai_active === 1'b0, "audio test kept over power off");
        send_cmd(RTLC_OP_CLOSE, RTLC_LOOP_D, 3'h0);
        test_sim = 1'b0;
        @(posedge clk_sys);
        #1;
        chk(loop_closed === 1'b0, "loop kept over sim removal");
        test_sim = 1'b1;
        $display("done audio");
    endtask

    initial begin
        reset = 1'b1;
        power_on = 1'b1;
        test_sim = 1'b1;
        tch_active = 1'b1;
        tch_kind = RTLC_TCH_FS;
        cmd_valid = 1'b0;
        cmd = '0;
        rx_valid = 1'b0;
        rx = '0;
        mode = 2'h0;
        ack = 1'b0;
        full_seen = 1'b0;
        miscompares = 0;
        num_checks = 0;
        repeat (12) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        t_refuse();
        t_variants();
        t_loops();
        t_dai();
        results();
    end
endmodule

bind rtlc_top rtlc_top_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) chk_i (.clk_sys, .reset,
    .power_on, .test_sim, .tch_active, .tch_kind, .cmd_valid, .cmd, .rx_valid, .rx, .rx_ready,
    .tx_valid, .tx, .tx_ready, .tx_own_tsc, .close_ack, .loop_closed, .dai_active,
    .loop_variant, .loop_chan);
`default_nettype wire
